// ===== pkg/dwmd_map.vh
// Offsets, field positions, codes and reset values of the word mode decoder
`ifndef DWMD_MAP_VH
`define DWMD_MAP_VH

// Bus word fields
`define DWMD_BIT_INSTR      15
`define DWMD_BIT_CTRL       14
`define DWMD_FLD_CODE_HI    13
`define DWMD_FLD_CODE_LO    11

// Status A fields carrying the pen hit enable and its write qualifier
`define DWMD_SA_PEN_VAL     5
`define DWMD_SA_PEN_WE      6

// Control mode codes held in the control mode register
`define DWMD_CTRL_GRAPHIC   3'h0
`define DWMD_CTRL_JUMP      3'h4
`define DWMD_CTRL_NOOP      3'h5
`define DWMD_CTRL_STAT_A    3'h6
`define DWMD_CTRL_STAT_B    3'h7

// Four bit selected mode codes seen by the 4-to-16 decoder
`define DWMD_CODE_GLYPH     4'h0
`define DWMD_CODE_SHORT_LN  4'h1
`define DWMD_CODE_LONG_LN   4'h2
`define DWMD_CODE_DOT       4'h3
`define DWMD_CODE_PLOT_X    4'h4
`define DWMD_CODE_PLOT_Y    4'h5
`define DWMD_CODE_REL_DOT   4'h6
`define DWMD_CODE_SPARE_D   4'h7
`define DWMD_CODE_GRAPHIC   4'h8
`define DWMD_CODE_SPARE_C1  4'h9
`define DWMD_CODE_SPARE_C2  4'hA
`define DWMD_CODE_SPARE_C3  4'hB
`define DWMD_CODE_JUMP      4'hC
`define DWMD_CODE_NOOP      4'hD
`define DWMD_CODE_STAT_A    4'hE
`define DWMD_CODE_STAT_B    4'hF

// Register word indices (byte address is four times the index)
`define DWMD_REG_CTRL       2'h0
`define DWMD_REG_STATUS     2'h1
`define DWMD_REG_WORD       2'h2
`define DWMD_REG_DECODE     2'h3

// Control register fields and reset values
`define DWMD_CTRL_RUN_BIT   0
`define DWMD_CTRL_UNHANG    1
`define DWMD_RUN_RESET      1'h1

`endif

// ===== rtl/dwmd_mode_regs.v
// Control and data mode registers with the control-word and word flags
`timescale 1ns/100ps
`include "dwmd_map.vh"

module dwmd_mode_regs (
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Latch request and bus word
    input  wire       load,
    input  wire [15:0] bus_data,
    // Register state
    output reg  [2:0] ctrl_mode_reg,
    output reg  [2:0] data_mode_reg,
    output reg        cont_word_reg,
    output reg        word_flag_reg,
    output reg        clear_word_reg
);

    wire       is_instr;
    wire       is_ctrl;
    wire [2:0] op_bits;

    assign is_instr = bus_data[`DWMD_BIT_INSTR];
    assign is_ctrl  = bus_data[`DWMD_BIT_CTRL];
    assign op_bits  = bus_data[`DWMD_FLD_CODE_HI:`DWMD_FLD_CODE_LO];

    // Mode registers change only on an instruction word
    always @(posedge clk) begin
        if (reset) begin
            ctrl_mode_reg <= `DWMD_CTRL_GRAPHIC;
            data_mode_reg <= 3'h0;
        end else if (load && is_instr) begin
            if (is_ctrl) begin
                ctrl_mode_reg <= op_bits;
            end else begin
                ctrl_mode_reg <= `DWMD_CTRL_GRAPHIC;
                data_mode_reg <= op_bits;
            end
        end
    end

    // Flags; load is withheld on a jump address word so nothing moves
    always @(posedge clk) begin
        if (reset) begin
            cont_word_reg  <= 1'b0;
            word_flag_reg  <= 1'b0;
            clear_word_reg <= 1'b0;
        end else begin
            clear_word_reg <= load && is_instr;
            if (load && is_instr) begin
                word_flag_reg <= 1'b0;
                cont_word_reg <= 1'b1;
            end else if (load) begin
                word_flag_reg <= 1'b1;
                cont_word_reg <= 1'b0;
            end
        end
    end

endmodule // dwmd_mode_regs

// ===== rtl/dwmd_decode.v
// Registered 4-to-16 mode decoder, one output asserted per decode
`timescale 1ns/100ps
`include "dwmd_map.vh"

module dwmd_decode (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Decode request
    input  wire        enable,
    input  wire [3:0]  code,
    // One-hot result
    output reg  [15:0] dec_reg,
    output reg         line_reg
);

    genvar i;

    // One flop per decoder output
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_dec
            always @(posedge clk) begin
                if (reset) begin
                    dec_reg[i] <= 1'b0;
                end else begin
                    dec_reg[i] <= enable && (code == i);
                end
            end
        end
    endgenerate

    // Short and long lines share one select output
    always @(posedge clk) begin
        if (reset) begin
            line_reg <= 1'b0;
        end else begin
            line_reg <= enable && ((code == `DWMD_CODE_SHORT_LN) ||
                                   (code == `DWMD_CODE_LONG_LN));
        end
    end

endmodule // dwmd_decode

// ===== rtl/dwmd_top.v
// Display word mode decoder top with Avalon-MM register slave
//
// Contract
// - Mode registers load on the load strobe with bit 15 set; every taken word except a jump address decodes.
// - Instruction word raises the clear strobe unless a jump address is due.
// - Clear-word strobe clears the word flag and sets the control-word flag.
// - Control-word flag set passes control mode; a control select decodes.
// - A data word after graphic mode clears the control-word flag.
// - Flag clear passes the data mode code; a graphic select decodes.
// - Jump address word cannot clock the control-word flag.
// - Multiplexer yields a four-bit code; decoder asserts one output.
// - Status A select loads bus bit 5 into the pen hit enable flag when bit 6 is set.
// - The pen hit enable flag decides whether pen hits are accepted.
// - Unused codes hang the processor; software must never issue them.
// - A data word leaves both mode registers unchanged.
// - A data word decodes the previously loaded data mode code.
// - Control instructions with bit 14 high keep the data mode register.
// - Bit 14 low stores graphic mode code and loads the data op code.
// - Control instruction bits 11 to 13 load the control mode register.
// - Multiplexer takes control mode for instructions, data mode for data.
// - Graphic mode stores control code 000; 100 jump, 101 no-op, 11x status.
// - While a jump is in effect neither mode register is clocked.
// - Data codes: glyph, lines, dot, plot x, plot y, relative dot, spare.
`timescale 1ns/100ps
`include "dwmd_map.vh"

module dwmd_top (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Fetched display word and timing
    input  wire [15:0] bus_data,
    input  wire        mode_load_strobe,
    input  wire        pen_hit,
    // Avalon-MM slave
    input  wire [1:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Word handling strobes and flags
    output wire        clear_word_strobe,
    output wire        control_word_selected,
    output reg         jump_second_word_reading,
    output reg  [3:0]  selected_mode_code,
    // Control operation selects
    output wire        graphic_mode_select,
    output wire        jump_select,
    output wire        noop_select,
    output wire        status_a_select,
    output wire        status_b_select,
    // Graphic operation selects
    output wire        glyph_op_select,
    output wire        line_op_select,
    output wire        dot_op_select,
    output wire        plot_x_select,
    output wire        plot_y_select,
    output wire        relative_dot_select,
    // Status flags
    output reg         pen_hit_enable,
    output reg         pen_hit_accepted,
    output reg         decode_hang
);

    // Sequencer states, one-hot
    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_DECODE = 3'b010;
    localparam [2:0] ST_JADDR  = 3'b100;

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [15:0] word_reg;
    reg         run_reg;
    reg  [15:0] last_dec_reg;
    reg         unhang_reg;

    wire [2:0]  ctrl_mode;
    wire [2:0]  data_mode;
    wire        cont_word;
    wire        word_flag;
    wire        clear_word;
    wire [15:0] dec;
    wire        line_dec;
    wire        accept;
    wire        jaddr_take;
    wire [3:0]  code_now;
    wire        code_unused;
    wire        do_decode;
    wire        bus_req;
    wire        bus_ack;

    // A strobe is taken only between decodes and while running
    assign accept = mode_load_strobe && (state_reg == ST_IDLE) &&
                    run_reg && !decode_hang;

    // The word after a jump is an address; it is consumed untouched
    assign jaddr_take = mode_load_strobe && (state_reg == ST_JADDR) &&
                        run_reg && !decode_hang;

    assign do_decode = (state_reg == ST_DECODE);

    // Mode select multiplexer, flag follows bit 15 of the last word
    assign code_now = cont_word ? {1'b1, ctrl_mode}
                                : {1'b0, data_mode};

    // Codes with no connection stall the processor
    assign code_unused = (code_now == `DWMD_CODE_SPARE_D)  ||
                         (code_now == `DWMD_CODE_SPARE_C1) ||
                         (code_now == `DWMD_CODE_SPARE_C2) ||
                         (code_now == `DWMD_CODE_SPARE_C3);

    // Mode registers and word flags
    dwmd_mode_regs u_mode_regs (
        .clk            (clk),
        .reset          (reset),
        .load           (accept),
        .bus_data       (bus_data),
        .ctrl_mode_reg  (ctrl_mode),
        .data_mode_reg  (data_mode),
        .cont_word_reg  (cont_word),
        .word_flag_reg  (word_flag),
        .clear_word_reg (clear_word)
    );

    // Registered 4-to-16 decode of the selected code
    dwmd_decode u_decode (
        .clk      (clk),
        .reset    (reset),
        .enable   (do_decode),
        .code     (code_now),
        .dec_reg  (dec),
        .line_reg (line_dec)
    );

    // Decoder flops drive the select outputs directly
    assign clear_word_strobe     = clear_word;
    assign control_word_selected = cont_word;
    assign graphic_mode_select   = dec[`DWMD_CODE_GRAPHIC];
    assign jump_select           = dec[`DWMD_CODE_JUMP];
    assign noop_select           = dec[`DWMD_CODE_NOOP];
    assign status_a_select       = dec[`DWMD_CODE_STAT_A];
    assign status_b_select       = dec[`DWMD_CODE_STAT_B];
    assign glyph_op_select       = dec[`DWMD_CODE_GLYPH];
    assign line_op_select        = line_dec;
    assign dot_op_select         = dec[`DWMD_CODE_DOT];
    assign plot_x_select         = dec[`DWMD_CODE_PLOT_X];
    assign plot_y_select         = dec[`DWMD_CODE_PLOT_Y];
    assign relative_dot_select   = dec[`DWMD_CODE_REL_DOT];

    // Sequencer next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    state_next = ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (word_reg[`DWMD_BIT_INSTR] &&
                    (code_now == `DWMD_CODE_JUMP)) begin
                    state_next = ST_JADDR;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_JADDR: begin
                if (jaddr_take) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Sequencer state and latched word
    always @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            word_reg  <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (accept) begin
                word_reg <= bus_data;
            end
        end
    end

    // Jump address pulse and the code shown at decode time
    always @(posedge clk) begin
        if (reset) begin
            jump_second_word_reading <= 1'b0;
            selected_mode_code       <= `DWMD_CODE_GRAPHIC;
        end else begin
            jump_second_word_reading <= jaddr_take;
            if (do_decode) begin
                selected_mode_code <= code_now;
            end
        end
    end

    // Status A load; only the pen enable is kept here, and only when
    // its write qualifier is set, so other status A loads leave it alone
    always @(posedge clk) begin
        if (reset) begin
            pen_hit_enable <= 1'b0;
        end else if (do_decode && (code_now == `DWMD_CODE_STAT_A) &&
                     word_reg[`DWMD_SA_PEN_WE]) begin
            pen_hit_enable <= word_reg[`DWMD_SA_PEN_VAL];
        end
    end

    // Pen hits pass only while enabled
    always @(posedge clk) begin
        if (reset) begin
            pen_hit_accepted <= 1'b0;
        end else begin
            pen_hit_accepted <= pen_hit && pen_hit_enable;
        end
    end

    // Hang on an unused code; set wins over a software release
    always @(posedge clk) begin
        if (reset) begin
            decode_hang <= 1'b0;
        end else if (do_decode && code_unused) begin
            decode_hang <= 1'b1;
        end else if (unhang_reg) begin
            decode_hang <= 1'b0;
        end
    end

    // Last decode kept for software inspection
    always @(posedge clk) begin
        if (reset) begin
            last_dec_reg <= 16'h0000;
        end else if (do_decode) begin
            last_dec_reg <= 16'h0001 << code_now;
        end
    end

    // Bus slave answers one cycle after a request is seen
    assign bus_req = avs_read || avs_write;
    assign bus_ack = bus_req && !avs_waitrequest;

    always @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else if (bus_req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Control register writes take effect on the acknowledging edge
    always @(posedge clk) begin
        if (reset) begin
            run_reg    <= `DWMD_RUN_RESET;
            unhang_reg <= 1'b0;
        end else begin
            unhang_reg <= 1'b0;
            if (bus_ack && avs_write &&
                (avs_address == `DWMD_REG_CTRL)) begin
                run_reg    <= avs_writedata[`DWMD_CTRL_RUN_BIT];
                unhang_reg <= avs_writedata[`DWMD_CTRL_UNHANG];
            end
        end
    end

    // Read data sampled when the request is first seen
    always @(posedge clk) begin
        if (reset) begin
            avs_readdata <= 32'h00000000;
        end else if (bus_req && avs_waitrequest && avs_read) begin
            case (avs_address)
                `DWMD_REG_CTRL: begin
                    avs_readdata <= {31'h00000000, run_reg};
                end
                `DWMD_REG_STATUS: begin
                    avs_readdata <= {23'h000000,
                                     (state_reg == ST_JADDR),
                                     decode_hang,
                                     pen_hit_enable,
                                     word_flag,
                                     cont_word,
                                     code_now};
                end
                `DWMD_REG_WORD: begin
                    avs_readdata <= {16'h0000, word_reg};
                end
                `DWMD_REG_DECODE: begin
                    avs_readdata <= {16'h0000, last_dec_reg};
                end
                default: begin
                    avs_readdata <= 32'h00000000;
                end
            endcase
        end
    end

endmodule // dwmd_top

// ===== sim/dwmd_word_source.sv
// Display memory model presenting fetched words with the load strobe
`timescale 1ns/100ps

module dwmd_word_source (
    // Clock
    input  wire        clk,
    // Word towards the decoder
    output reg  [15:0] bus_data,
    output reg         mode_load_strobe
);
    // Idle bus shows a pattern before the first word, then the inverted last word, so a stale word is never mistaken for data
    initial begin
        bus_data = 16'h5A5A;
        mode_load_strobe = 1'b0;
    end

    // One word per call; the bus shows the inverted word right after the strobe edge
    task send(input [15:0] w);
        begin
            @(posedge clk);
            bus_data <= w;
            mode_load_strobe <= 1'b1;
            @(posedge clk);
            bus_data <= ~w;
            mode_load_strobe <= 1'b0;
        end
    endtask
endmodule // dwmd_word_source

// ===== sim/dwmd_top_monitor.sv
// Concurrent checks on the word mode decoder ports
`timescale 1ns/100ps

module dwmd_monitor (
    // Clock and reset
    input wire        clk,
    input wire        reset,
    // Word input
    input wire        mode_load_strobe,
    input wire        pen_hit,
    // Word handling
    input wire        clear_word_strobe,
    input wire        control_word_selected,
    input wire        jump_second_word_reading,
    input wire [3:0]  selected_mode_code,
    // Selects
    input wire        graphic_mode_select,
    input wire        jump_select,
    input wire        noop_select,
    input wire        status_a_select,
    input wire        status_b_select,
    input wire        glyph_op_select,
    input wire        line_op_select,
    input wire        dot_op_select,
    input wire        plot_x_select,
    input wire        plot_y_select,
    input wire        relative_dot_select,
    // Pen flags
    input wire        pen_hit_enable,
    input wire        pen_hit_accepted
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Grouped selects keep the one-hot check to one line
    wire [4:0] ctl = {graphic_mode_select, jump_select, noop_select,
                      status_a_select, status_b_select};
    wire [5:0] dat = {glyph_op_select, line_op_select, dot_op_select,
                      plot_x_select, plot_y_select, relative_dot_select};

    a_clear_cause: assert property (clear_word_strobe |->
        $past(mode_load_strobe)) else $error("clear strobe without word");
    a_clear_sets_flag: assert property (clear_word_strobe |->
        control_word_selected) else $error("flag not set by clear");
    a_one_select: assert property ($onehot0({ctl, dat}))
        else $error("more than one select");
    a_ctrl_flagged: assert property ((|ctl) |->
        control_word_selected) else $error("control select, flag clear");
    a_data_unflagged: assert property ((|dat) |->
        !control_word_selected && !selected_mode_code[3])
        else $error("data select with control source");
    a_graphic_code: assert property (graphic_mode_select |->
        selected_mode_code == 4'h8) else $error("graphic code wrong");
    a_status_code: assert property (status_a_select |->
        selected_mode_code == 4'hE) else $error("status a code wrong");
    a_jump_noop_code: assert property (
        (jump_select || noop_select) |->
        selected_mode_code == {3'h6, noop_select})
        else $error("jump or noop code wrong");
    a_select_cause: assert property ((|{ctl, dat}) |->
        $past(mode_load_strobe, 2)) else $error("select without strobe");
    a_jump_addr_quiet: assert property (
        jump_second_word_reading |->
        !clear_word_strobe && $stable(control_word_selected))
        else $error("jump address moved the flag");
    a_pen_accept: assert property (pen_hit_accepted ==
        ($past(pen_hit) && $past(pen_hit_enable)))
        else $error("pen hit acceptance wrong");
    a_pen_from_status: assert property (!$stable(pen_hit_enable) |->
        status_a_select) else $error("pen enable moved alone");
    a_line_code: assert property (line_op_select |->
        (selected_mode_code == 4'h1 || selected_mode_code == 4'h2))
        else $error("line code wrong");
endmodule // dwmd_monitor

bind dwmd_top dwmd_monitor u_mon (
    .clk(clk), .reset(reset), .mode_load_strobe(mode_load_strobe),
    .pen_hit(pen_hit), .clear_word_strobe(clear_word_strobe),
    .control_word_selected(control_word_selected),
    .jump_second_word_reading(jump_second_word_reading),
    .selected_mode_code(selected_mode_code),
    .graphic_mode_select(graphic_mode_select), .jump_select(jump_select),
    .noop_select(noop_select), .status_a_select(status_a_select),
    .status_b_select(status_b_select), .glyph_op_select(glyph_op_select),
    .line_op_select(line_op_select), .dot_op_select(dot_op_select),
    .plot_x_select(plot_x_select), .plot_y_select(plot_y_select),
    .relative_dot_select(relative_dot_select),
    .pen_hit_enable(pen_hit_enable), .pen_hit_accepted(pen_hit_accepted));

// ===== sim/test_dwmd_top.sv
// Self-checking bench for the word mode decoder
`timescale 1ns/100ps

module test_dwmd_top;
    reg         clk;
    reg         reset;
    reg         pen_hit;
    reg  [1:0]  avs_address;
    reg         avs_read;
    reg         avs_write;
    reg  [31:0] avs_writedata;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire [15:0] bus_data;
    wire        mode_load_strobe;
    wire        clear_word_strobe;
    wire        control_word_selected;
    wire        jump_second_word_reading;
    wire [3:0]  selected_mode_code;
    wire [10:0] sel;
    wire        pen_hit_enable;
    wire        pen_hit_accepted;
    wire        decode_hang;
    integer     failures;
    integer     tests_run;
    integer     i;
    reg  [31:0] rd;

    dwmd_word_source SRC (.clk(clk), .bus_data(bus_data),
        .mode_load_strobe(mode_load_strobe));

    dwmd_top DUT (.clk(clk), .reset(reset), .bus_data(bus_data),
        .mode_load_strobe(mode_load_strobe), .pen_hit(pen_hit),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .clear_word_strobe(clear_word_strobe),
        .control_word_selected(control_word_selected),
        .jump_second_word_reading(jump_second_word_reading),
        .selected_mode_code(selected_mode_code),
        .graphic_mode_select(sel[10]), .jump_select(sel[9]),
        .noop_select(sel[8]), .status_a_select(sel[7]),
        .status_b_select(sel[6]), .glyph_op_select(sel[5]),
        .line_op_select(sel[4]), .dot_op_select(sel[3]),
        .plot_x_select(sel[2]), .plot_y_select(sel[1]),
        .relative_dot_select(sel[0]), .pen_hit_enable(pen_hit_enable),
        .pen_hit_accepted(pen_hit_accepted), .decode_hang(decode_hang));

    // Short and long vectors share one select, so op 2 repeats op 1
    function [10:0] op_sel(input [2:0] op);
        op_sel = 11'h020 >> (op - (op > 3'h1));
    endfunction

    task check(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task complete_run;
        begin
            if (failures == 0 && tests_run > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask

    // Avalon access held until waitrequest is sampled low
    task bus(input wr, input [1:0] a, input [31:0] wd, output [31:0] q);
        integer n;
        begin
            @(posedge clk);
            avs_address <= a;
            avs_writedata <= wd;
            avs_read <= !wr;
            avs_write <= wr;
            n = 0;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0 && n < 20) begin
                n = n + 1;
                @(posedge clk);
            end
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            if (n == 20) begin
                failures = failures + 1;
                complete_run;
            end
        end
    endtask

    // One word: strobe and flag in cycle 1, decode in cycle 2
    task word(input [15:0] w, input clr, input flg, input j,
              input [10:0] s, input [3:0] code);
        begin
            SRC.send(w);
            #1;
            check(clear_word_strobe, clr);
            check(control_word_selected, flg);
            check(jump_second_word_reading, j);
            @(posedge clk);
            #1;
            check(sel, s);
            check(selected_mode_code, code);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures = failures + 1;
        complete_run;
    end

    initial begin
        failures = 0;
        tests_run = 0;
        reset = 1'b1;
        pen_hit = 1'b0;
        avs_address = 2'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        #1;
        check(selected_mode_code, 4'h8);
        bus(1'b0, 2'h0, 32'h0, rd);
        check(rd, 32'h1);
        // Every graphic op: mode instruction, then two data words
        for (i = 0; i < 7; i = i + 1) begin
            word({2'h2, i[2:0], 11'h0}, 1, 1, 0, 11'h400, 4'h8);
            word(16'h0123, 0, 0, 0, op_sel(i), i[3:0]);
            word(16'h0456, 0, 0, 0, op_sel(i), i[3:0]);
        end
        word(16'h9000, 1, 1, 0, 11'h400, 4'h8);
        word(16'hE800, 1, 1, 0, 11'h100, 4'hD);
        word(16'h0001, 0, 0, 0, 11'h010, 4'h2);
        word(16'hF060, 1, 1, 0, 11'h080, 4'hE);
        word(16'hF020, 1, 1, 0, 11'h080, 4'hE);
        check(pen_hit_enable, 1'b1);
        @(posedge clk);
        pen_hit <= 1'b1;
        @(posedge clk);
        pen_hit <= 1'b0;
        #1;
        check(pen_hit_accepted, 1'b1);
        word(16'hF040, 1, 1, 0, 11'h080, 4'hE);
        check(pen_hit_enable, 1'b0);
        // A hit while disabled must not pass
        @(posedge clk);
        pen_hit <= 1'b1;
        @(posedge clk);
        pen_hit <= 1'b0;
        #1;
        check(pen_hit_accepted, 1'b0);
        word(16'hF800, 1, 1, 0, 11'h040, 4'hF);
        word(16'hE000, 1, 1, 0, 11'h200, 4'hC);
        word(16'hC123, 0, 1, 1, 11'h000, 4'hC);
        word(16'h0002, 0, 0, 0, 11'h010, 4'h2);
        // Control code 000 shows graphic mode but keeps the data op
        word(16'hC000, 1, 1, 0, 11'h400, 4'h8);
        word(16'h0003, 0, 0, 0, 11'h010, 4'h2);
        // Stopped decoder ignores words
        bus(1'b1, 2'h0, 32'h0, rd);
        word(16'hE800, 0, 0, 0, 11'h000, 4'h2);
        bus(1'b1, 2'h0, 32'h1, rd);
        // Spare data op hangs until software releases it
        word(16'hB800, 1, 1, 0, 11'h400, 4'h8);
        word(16'h0077, 0, 0, 0, 11'h000, 4'h7);
        check(decode_hang, 1'b1);
        word(16'hE800, 0, 0, 0, 11'h000, 4'h7);
        bus(1'b0, 2'h3, 32'h0, rd);
        check(rd, 32'h80);
        bus(1'b1, 2'h3, 32'hFFFF, rd);
        bus(1'b0, 2'h3, 32'h0, rd);
        check(rd, 32'h80);
        bus(1'b0, 2'h2, 32'h0, rd);
        check(rd, 32'h0077);
        bus(1'b0, 2'h1, 32'h0, rd);
        check(rd, 32'hA7);
        bus(1'b1, 2'h0, 32'h3, rd);
        bus(1'b0, 2'h1, 32'h0, rd);
        check(rd, 32'h27);
        // Spare control code hangs as well
        word(16'hC800, 1, 1, 0, 11'h000, 4'h9);
        check(decode_hang, 1'b1);
        bus(1'b1, 2'h0, 32'h3, rd);
        word(16'hE800, 1, 1, 0, 11'h100, 4'hD);
        complete_run;
    end
endmodule // test_dwmd_top
